// ---- hdl/wd_pkg.sv ----
// Purpose: Shared constants and types for the watchdog timer block.
// Assumes: One 125 MHz clock; registers reached over AHB-Lite with 32-bit data.
// Notes:   Register indices are word indices; the byte address is four times the index.

package wd_pkg;

  // ********************************************************************
  // Register indices
  // ********************************************************************
  localparam logic [15:0] IDX_CTRL       = 16'h4004;
  localparam logic [15:0] IDX_INT_STATUS = 16'h4011;
  localparam logic [15:0] IDX_INT_MASK   = 16'h4019;
  localparam logic [15:0] IDX_SECURITY   = 16'h4020;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h4021;
  localparam logic [15:0] IDX_IRQ_CLEAR  = 16'h4022;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'h4023;
  localparam logic [15:0] IDX_WD_STATE   = 16'h4024;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_ENABLE   = 15;
  localparam int BIT_PAUSE    = 14;
  localparam int BIT_SRC      = 13;
  localparam int BIT_SLEEP    = 12;
  localparam int BIT_SWRST    = 11;
  localparam int SECOND_LSB   = 8;
  localparam int FIRST_LSB    = 4;
  localparam int PERIOD_LSB   = 0;
  localparam int BIT_TO_FLAG  = 11;
  localparam int IRQ_W        = 3;
  localparam int IRQ_FIRST    = 0;
  localparam int IRQ_SECOND   = 1;
  localparam int IRQ_EXHAUST  = 2;
  localparam int STATE_ATT_LSB = 4;

  // ********************************************************************
  // Types and reset values
  // ********************************************************************
  typedef enum logic [1:0] {ACT_NONE, ACT_IRQ, ACT_RESET, ACT_WAKE} action_t;
  typedef enum logic [1:0] {STAGE_FIRST, STAGE_SECOND, STAGE_SPENT} stage_t;

  typedef struct packed {
    logic       enable;
    logic       pause;
    logic       src_sw;
    logic       sleep_run;
    action_t    second;
    action_t    first;
    logic [2:0] period;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{enable: 1'b1, pause: 1'b0, src_sw: 1'b1, sleep_run: 1'b0,
                                   second: ACT_RESET, first: ACT_IRQ, period: 3'h7};
  localparam logic        MASK_RESET = 1'b1;
  localparam logic [15:0] UNLOCK_KEY = 16'h5a3c;   // Arbitrary value.
  localparam logic [2:0]  MAX_STARTUP_ATTEMPTS = 3'h7;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam longint      CORE_CLK_NS      = 8;
  localparam longint      WD_BASE_NS       = 256000000;
  localparam int unsigned WD_BASE_CYCLES   = 32'(WD_BASE_NS / CORE_CLK_NS);
  localparam longint      RESET_HOLD_NS    = 1000;
  localparam logic [7:0]  RESET_HOLD_CYCLES = 8'((RESET_HOLD_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);

endpackage

// ---- hdl/wd_timer.sv ----
// Purpose: Watchdog timer with two timeout stages, selectable restart source and key lock.
// Assumes: core_clk is the internal oscillator clock; sleep_state comes from same-domain logic.
// Notes:   All state freezes while ce is low, the bus included, so software keeps ce high.

// Contract
// [R01] Free-running counter on the oscillator clock.
// [R02] Enable bit 15 resets set; no restart.
// [R03] In sleep, stop unless bit 12 set.
// [R04] Pause bit 14 holds the counter.
// [R05] Period code doubles from 0.256s, default 111.
// [R06] Bit 13 selects restart source; other ignored.
// [R07] Software restart by writing bit 11.
// [R08] Each toggle of restart pin restarts.
// [R09] First timeout runs the primary action.
// [R10] Second timeout runs the secondary action.
// [R11] Reset action: pin, register defaults, start-up.
// [R12] At most seven start-up attempts.
// [R13] Control writes need the unlock key.
// [R14] Timeout sets flag bit 11; write-one clears.
// [R15] Flag drives primary interrupt unless masked.
// [R16] Restart zeroes counter and rearms both stages.
// [R17] Pin synchronised, both edges are toggles.
module wd_timer #(
  parameter int unsigned BASE_CYCLES = wd_pkg::WD_BASE_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sleep_state,
  input  wire logic        wd_restart_pin,
  output logic             wd_primary_irq,
  output logic             irq,
  output logic             dev_reset_out,
  output logic             startup_req,
  output logic             wake_req,
  output wd_pkg::stage_t   wd_stage
);
  import wd_pkg::*;

  // ********************************************************************
  // Bus slave
  // ********************************************************************
  logic [15:0] addr_idx_reg;
  logic        wr_pend_reg;
  logic [31:0] hrdata_reg;
  logic        hreadyout_reg;
  logic        hresp_reg;

  wire         take    = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire         aligned = (haddr[1:0] == 2'h0) && (haddr[31:18] == 14'h0000);
  wire  [15:0] a_idx   = haddr[17:2];

  ctrl_t                ctrl_reg;
  logic                 unlock_reg;
  logic                 to_flag_reg;
  logic                 mask_reg;
  logic [IRQ_W-1:0]     irq_status_reg;
  logic [IRQ_W-1:0]     irq_en_reg;
  logic [31:0]          cnt_reg;
  stage_t               stage_reg;
  logic [7:0]           rst_cnt_reg;
  logic [2:0]           att_reg;

  wire         wr_ctrl   = wr_pend_reg && addr_idx_reg == IDX_CTRL;
  wire         wr_status = wr_pend_reg && addr_idx_reg == IDX_INT_STATUS;
  wire         wr_mask   = wr_pend_reg && addr_idx_reg == IDX_INT_MASK;
  wire         wr_sec    = wr_pend_reg && addr_idx_reg == IDX_SECURITY;
  wire         wr_iclr   = wr_pend_reg && addr_idx_reg == IDX_IRQ_CLEAR;
  wire         wr_ien    = wr_pend_reg && addr_idx_reg == IDX_IRQ_ENABLE;
  wire         ctrl_ok   = wr_ctrl && unlock_reg;   // R13

  wire  [15:0] ctrl_rd = {ctrl_reg.enable, ctrl_reg.pause, ctrl_reg.src_sw, ctrl_reg.sleep_run, 2'h0,
                          ctrl_reg.second, 2'h0, ctrl_reg.first, 1'b0, ctrl_reg.period};
  logic [31:0] rd_mux;
  always_comb begin
    if (!aligned) begin
      rd_mux = 32'h0000_0000;
    end else if (a_idx == IDX_CTRL) begin
      rd_mux = {16'h0000, ctrl_rd};
    end else if (a_idx == IDX_INT_STATUS) begin
      rd_mux = 32'(to_flag_reg) << BIT_TO_FLAG;
    end else if (a_idx == IDX_INT_MASK) begin
      rd_mux = 32'(mask_reg) << BIT_TO_FLAG;
    end else if (a_idx == IDX_SECURITY) begin
      rd_mux = 32'(unlock_reg);
    end else if (a_idx == IDX_IRQ_STATUS) begin
      rd_mux = 32'(irq_status_reg);
    end else if (a_idx == IDX_IRQ_ENABLE) begin
      rd_mux = 32'(irq_en_reg);
    end else if (a_idx == IDX_WD_STATE) begin
      rd_mux = {25'h0, att_reg, 2'b00, stage_reg};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_idx_reg  <= 16'h0000;
      wr_pend_reg   <= 1'b0;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else if (ce) begin
      addr_idx_reg  <= aligned ? a_idx : 16'hffff;
      wr_pend_reg   <= take && hwrite;
      hrdata_reg    <= (take && !hwrite) ? rd_mux : hrdata_reg;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
  end

  // ********************************************************************
  // Restart sources
  // ********************************************************************
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_s3_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else if (ce) begin
      pin_s1_reg <= wd_restart_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  wire pin_toggle = pin_s2_reg ^ pin_s3_reg;                    // R17
  wire hw_hit     = pin_toggle && !ctrl_reg.src_sw;             // R08 R06
  wire sw_hit     = ctrl_ok && hwdata[BIT_SWRST] && ctrl_reg.src_sw;  // R07 R06
  wire restart    = hw_hit || sw_hit;

  // ********************************************************************
  // Counter and timeout stages
  // ********************************************************************
  wire         in_reset = rst_cnt_reg != 8'h00;
  wire         awake_ok = !sleep_state || ctrl_reg.sleep_run;                // R03
  wire         active   = ctrl_reg.enable && !ctrl_reg.pause && awake_ok;    // R02 R04
  wire  [31:0] period   = BASE_CYCLES << ctrl_reg.period;                    // R05
  // A shorter period written mid-count must still expire, so the compare is not exact.
  wire         terminal = cnt_reg >= period - 32'h1;
  wire         timeout  = active && terminal && stage_reg != STAGE_SPENT && !restart && !in_reset;
  wire         counting = active && stage_reg != STAGE_SPENT;                // R10
  wire         first_to = timeout && stage_reg == STAGE_FIRST;
  wire         act_sel  = first_to;
  wire action_t act     = act_sel ? ctrl_reg.first : ctrl_reg.second;        // R09 R10
  wire         want_rst = timeout && act == ACT_RESET;
  wire         do_reset = want_rst && att_reg < MAX_STARTUP_ATTEMPTS;        // R12
  wire         exhaust  = want_rst && att_reg == MAX_STARTUP_ATTEMPTS;

  wire  [31:0] cnt_next = (restart || in_reset || timeout) ? 32'h0 :        // R16
                          counting ? cnt_reg + 32'h1 : cnt_reg;              // R01
  wire stage_t stage_next = (restart || in_reset) ? STAGE_FIRST :           // R16
                            !timeout ? stage_reg :
                            first_to ? STAGE_SECOND : STAGE_SPENT;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= 32'h0;
      stage_reg <= STAGE_FIRST;
    end else if (ce) begin
      cnt_reg   <= cnt_next;
      stage_reg <= stage_next;
    end
  end

  // ********************************************************************
  // Control, lock and device reset sequence
  // ********************************************************************
  wire ctrl_t ctrl_wr = '{enable: hwdata[BIT_ENABLE], pause: hwdata[BIT_PAUSE], src_sw: hwdata[BIT_SRC],
                         sleep_run: hwdata[BIT_SLEEP], second: action_t'(hwdata[SECOND_LSB +: 2]),
                         first: action_t'(hwdata[FIRST_LSB +: 2]), period: hwdata[PERIOD_LSB +: 3]};
  wire [7:0] rst_cnt_next = do_reset ? RESET_HOLD_CYCLES : in_reset ? rst_cnt_reg - 8'h1 : 8'h00;

  // A watchdog reset returns the control fields and the lock to defaults but keeps
  // the attempt count, which is what bounds a fault that keeps coming back.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= CTRL_RESET;
      unlock_reg <= 1'b0;
      mask_reg   <= MASK_RESET;
    end else if (ce) begin
      if (do_reset) begin                                  // R11
        ctrl_reg   <= CTRL_RESET;
        unlock_reg <= 1'b0;
        mask_reg   <= MASK_RESET;
      end else begin
        ctrl_reg   <= ctrl_ok ? ctrl_wr : ctrl_reg;        // R13
        unlock_reg <= wr_sec ? (hwdata[15:0] == UNLOCK_KEY) : unlock_reg;  // R13
        mask_reg   <= wr_mask ? hwdata[BIT_TO_FLAG] : mask_reg;
      end
    end
  end

  logic dev_reset_out_reg;
  logic startup_req_reg;
  logic wake_req_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_cnt_reg       <= 8'h00;
      att_reg           <= 3'h0;
      dev_reset_out_reg <= 1'b0;
      startup_req_reg   <= 1'b0;
      wake_req_reg      <= 1'b0;
    end else if (ce) begin
      rst_cnt_reg       <= rst_cnt_next;
      att_reg           <= restart ? 3'h0 : do_reset ? att_reg + 3'h1 : att_reg;   // R12
      dev_reset_out_reg <= rst_cnt_next != 8'h00;                                 // R11
      startup_req_reg   <= rst_cnt_reg == 8'h01;                                  // R11
      wake_req_reg      <= timeout && act == ACT_WAKE;                            // R09 R10
    end
  end

  // ********************************************************************
  // Interrupts
  // ********************************************************************
  // The set term wins over a write-one clear in the same cycle.
  wire                 flag_clr   = wr_status && hwdata[BIT_TO_FLAG];
  wire                 flag_next  = timeout || (to_flag_reg && !flag_clr);              // R14
  wire [IRQ_W-1:0]     ev_set     = {exhaust, timeout && !first_to, first_to};
  wire [IRQ_W-1:0]     ev_clr     = wr_iclr ? hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0]     irq_status_next = ev_set | (irq_status_reg & ~ev_clr);

  logic wd_primary_irq_reg;
  logic irq_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      to_flag_reg        <= 1'b0;
      irq_status_reg     <= {IRQ_W{1'b0}};
      irq_en_reg         <= {IRQ_W{1'b0}};
      wd_primary_irq_reg <= 1'b0;
      irq_reg            <= 1'b0;
    end else if (ce) begin
      to_flag_reg        <= flag_next;
      irq_status_reg     <= irq_status_next;
      irq_en_reg         <= wr_ien ? hwdata[IRQ_W-1:0] : irq_en_reg;
      wd_primary_irq_reg <= to_flag_reg && !mask_reg;                   // R15
      irq_reg            <= |(irq_status_reg & irq_en_reg);
    end
  end

  assign hrdata         = hrdata_reg;
  assign hreadyout      = hreadyout_reg;
  assign hresp          = hresp_reg;
  assign wd_primary_irq = wd_primary_irq_reg;
  assign irq            = irq_reg;
  assign dev_reset_out  = dev_reset_out_reg;
  assign startup_req    = startup_req_reg;
  assign wake_req       = wake_req_reg;
  assign wd_stage       = stage_reg;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_sw_restart_zero: assert property ( // R07
    (ce && sw_hit) |=> (cnt_reg == 32'h0 && stage_reg == STAGE_FIRST))
    else $error("software restart did not clear the counter");

  a_hw_toggle_zero: assert property ( // R17
    (ce && !in_reset && !ctrl_reg.src_sw && $changed(pin_s2_reg) && $past(ce))
    |=> (cnt_reg == 32'h0 && stage_reg == STAGE_FIRST))
    else $error("pin toggle did not restart the counter");

  a_wrong_src_ignored: assert property ( // R06
    (ce && ctrl_reg.src_sw && pin_toggle && !sw_hit && active && !in_reset && !terminal
    && stage_reg != STAGE_SPENT) |=> cnt_reg == $past(cnt_reg) + 32'h1)
    else $error("deselected pin source restarted the counter");

  a_pause_holds: assert property ( // R04
    (ce && ctrl_reg.pause && !restart && !in_reset) |=> $stable(cnt_reg))
    else $error("paused counter moved");

  a_disable_holds: assert property ( // R02
    (ce && !ctrl_reg.enable && !restart && !in_reset) |=> $stable(cnt_reg))
    else $error("disabled counter moved");

  a_sleep_stops: assert property ( // R03
    (ce && sleep_state && !ctrl_reg.sleep_run && !restart && !in_reset) |=> $stable(cnt_reg))
    else $error("counter ran in sleep");

  a_stage_advance: assert property ( // R09
    (ce && first_to) |=> (stage_reg == STAGE_SECOND && cnt_reg == 32'h0))
    else $error("primary timeout did not advance stage");

  a_timeout_flag: assert property ( // R14
    (ce && timeout) |=> to_flag_reg)
    else $error("timeout flag not set");

  a_flag_clear: assert property ( // R14
    (ce && flag_clr && !timeout) |=> !to_flag_reg)
    else $error("timeout flag not cleared");

  a_mask_blocks: assert property ( // R15
    (ce && mask_reg) |=> !wd_primary_irq_reg)
    else $error("masked flag raised interrupt");

  a_reset_pulse: assert property ( // R11
    (ce && do_reset) |=> (dev_reset_out_reg && ctrl_reg == CTRL_RESET && !unlock_reg))
    else $error("reset action incomplete");

  a_attempt_limit: assert property ( // R12
    (ce && exhaust && !in_reset) |=> (!dev_reset_out_reg && att_reg == MAX_STARTUP_ATTEMPTS))
    else $error("start-up attempted beyond limit");

  a_locked_ctrl: assert property ( // R13
    (ce && wr_ctrl && !unlock_reg && !do_reset) |=> $stable(ctrl_reg))
    else $error("locked control field changed");

  a_wake_pulse: assert property ( // R09
    (ce && timeout && act == ACT_WAKE) |=> wake_req_reg)
    else $error("wake action not requested");

  a_no_wake: assert property ( // R09
    (ce && !timeout) |=> !wake_req_reg)
    else $error("wake request without timeout");

  a_second_spent: assert property ( // R10
    (ce && timeout && !first_to) |=> stage_reg == STAGE_SPENT)
    else $error("secondary timeout did not end the stages");

  a_spent_stops: assert property ( // R10
    (ce && stage_reg == STAGE_SPENT && !restart && !in_reset) |=> $stable(cnt_reg))
    else $error("counter ran after both timeouts");

  a_startup_pulse: assert property ( // R11
    (ce && rst_cnt_reg == 8'h01) |=> (startup_req_reg && !dev_reset_out_reg))
    else $error("start-up request missing at end of reset");

  a_reset_held: assert property ( // R11
    (ce && in_reset && rst_cnt_reg != 8'h01) |=> dev_reset_out_reg)
    else $error("reset output dropped early");

  a_unlock_key: assert property ( // R13
    (ce && wr_sec && !do_reset) |=> unlock_reg == $past(hwdata[15:0] == UNLOCK_KEY))
    else $error("lock state does not follow the key");

  a_ctrl_write: assert property ( // R13
    (ce && ctrl_ok && !do_reset) |=> ctrl_reg == $past(ctrl_wr))
    else $error("unlocked control write lost");

  a_sw_needs_key: assert property ( // R13
    (ce && wr_ctrl && !unlock_reg && ctrl_reg.src_sw && hwdata[BIT_SWRST] && active && !terminal
    && !in_reset && stage_reg != STAGE_SPENT) |=> cnt_reg == $past(cnt_reg) + 32'h1)
    else $error("locked software restart took effect");

  a_att_cleared: assert property ( // R16
    (ce && restart) |=> att_reg == 3'h0)
    else $error("restart kept the attempt count");

  a_first_status: assert property ( // R09
    (ce && first_to) |=> irq_status_reg[IRQ_FIRST])
    else $error("primary timeout event not recorded");

  a_exhaust_status: assert property ( // R12
    (ce && exhaust) |=> irq_status_reg[IRQ_EXHAUST])
    else $error("exhausted attempts not recorded");

  a_irq_level: assert property (
    ce |=> irq_reg == $past(|(irq_status_reg & irq_en_reg)))
    else $error("interrupt level does not follow enabled status");

  a_flag_primary: assert property ( // R15
    ce |=> wd_primary_irq_reg == $past(to_flag_reg && !mask_reg))
    else $error("primary interrupt does not follow the flag");

  a_bus_okay: assert property (
    ce |=> (hreadyout_reg && !hresp_reg))
    else $error("bus answer not ready and okay");

endmodule

// ---- dv/wd_host_pin.sv ----
// Purpose: Host side model that services the watchdog by toggling its restart pin.
// Assumes: Driven from the same clock as the block; toggles only while toggle_on is high.
// Notes:   The pin holds its last level when idle, as a real push-pull output would.

module wd_host_pin #(
  parameter int HALF = 10
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic toggle_on,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // ********************************************************************
  // Toggle generator
  // ********************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin <= 1'b0;
      cnt <= 0;
    end else if (toggle_on) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) pin <= ~pin;
    end
  end
endmodule

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the watchdog timer over its register bus.
// Assumes: Short base period so every timeout fits in a brief run.
// Notes:   Only mismatches and the verdict are printed.

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wd_pkg::*;
  localparam int BASE = 16;
  localparam logic [31:0] DEF = 32'ha217;
  logic        core_clk = 0, rst = 1, hsel = 0, hwrite = 0, sleep_state = 0, toggle_on = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, pin, wd_primary_irq, irq, dev_reset_out, startup_req, wake_req;
  stage_t      wd_stage;
  logic [4:0]  mode [4] = '{5'b00100, 5'b11100, 5'b10101, 5'b10111};
  int          mismatches = 0, comparisons = 0, cycles = 0, starts = 0, n;

  wd_timer #(.BASE_CYCLES(BASE)) i_dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleep_state(sleep_state), .wd_restart_pin(pin), .wd_primary_irq(wd_primary_irq), .irq(irq),
    .dev_reset_out(dev_reset_out), .startup_req(startup_req), .wake_req(wake_req), .wd_stage(wd_stage));
  wd_host_pin #(.HALF(5)) i_host (.core_clk(core_clk), .rst(rst), .toggle_on(toggle_on), .pin(pin));

  always #4 core_clk = ~core_clk;

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A hang on the bus or a silent timer must still end in the verdict.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (startup_req === 1'b1) starts <= starts + 1;
    if (cycles == 50000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic [15:0] idx, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {14'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [31:0] e);
    bus(idx, 1'b0, 32'h0);
    chk(rd, e);
    chk(hresp, 1'b0);
  endtask

  function automatic logic [31:0] cw(input logic [3:0] top, input logic sw, input logic [1:0] s,
                                     input logic [1:0] f, input logic [2:0] p);
    return {16'h0, top, sw, 1'b0, s, 2'b00, f, 1'b0, p};
  endfunction

  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (n < lim && ((sel == 0) ? wd_primary_irq : (sel == 1) ? wake_req : dev_reset_out) !== 1'b1) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // ********************************************************************
  // Sequence
  // ********************************************************************
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rchk(IDX_CTRL, DEF);
    rchk(IDX_INT_MASK, 32'h800);
    rchk(IDX_INT_STATUS, 32'h0);
    rchk(16'h4030, 32'h0);
    bus(IDX_CTRL, 1'b1, cw(4'h2, 1'b1, ACT_NONE, ACT_NONE, 3'h0));
    rchk(IDX_CTRL, DEF);
    bus(IDX_SECURITY, 1'b1, {16'h0, UNLOCK_KEY});
    bus(IDX_INT_MASK, 1'b1, 32'h0);
    bus(IDX_IRQ_ENABLE, 1'b1, 32'h3);
    for (int p = 0; p < 3; p++) begin
      bus(IDX_INT_STATUS, 1'b1, 32'h800);
      bus(IDX_CTRL, 1'b1, cw(4'ha, 1'b1, ACT_WAKE, ACT_IRQ, p[2:0]));
      wait_for(0, 2000);
      chk(32'(n >= (BASE << p) && n <= (BASE << p) + 2), 32'h1);
    end
    wait_for(1, 200);
    chk(wake_req, 1'b1);
    repeat (2) @(posedge core_clk);
    chk(wd_stage, STAGE_SPENT);
    chk(irq, 1'b1);
    rchk(IDX_IRQ_STATUS, 32'h3);
    bus(IDX_IRQ_CLEAR, 1'b1, 32'h3);
    rchk(IDX_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    bus(IDX_INT_MASK, 1'b1, 32'h800);
    repeat (2) @(posedge core_clk);
    chk(wd_primary_irq, 1'b0);
    rchk(IDX_INT_STATUS, 32'h800);
    bus(IDX_INT_STATUS, 1'b1, 32'h800);
    rchk(IDX_INT_STATUS, 32'h0);
    // Disabled, paused, asleep, then asleep but allowed to run.
    for (int i = 0; i < 4; i++) begin
      sleep_state <= mode[i][0];
      bus(IDX_INT_STATUS, 1'b1, 32'h800);
      bus(IDX_CTRL, 1'b1, cw(mode[i][4:1], 1'b1, ACT_NONE, ACT_IRQ, 3'h0));
      repeat (80) @(posedge core_clk);
      rchk(IDX_INT_STATUS, (i == 3) ? 32'h800 : 32'h0);
    end
    sleep_state <= 1'b0;
    bus(IDX_INT_STATUS, 1'b1, 32'h800);
    bus(IDX_CTRL, 1'b1, cw(4'ha, 1'b1, ACT_NONE, ACT_IRQ, 3'h0));
    bus(IDX_CTRL, 1'b1, cw(4'h8, 1'b0, ACT_NONE, ACT_IRQ, 3'h0));
    toggle_on <= 1'b1;
    repeat (200) @(posedge core_clk);
    rchk(IDX_INT_STATUS, 32'h0);
    toggle_on <= 1'b0;
    repeat (6) begin
      bus(IDX_CTRL, 1'b1, cw(4'h8, 1'b1, ACT_NONE, ACT_IRQ, 3'h0));
      repeat (8) @(posedge core_clk);
    end
    rchk(IDX_INT_STATUS, 32'h800);
    repeat (2) bus(IDX_CTRL, 1'b1, cw(4'ha, 1'b1, ACT_RESET, ACT_RESET, 3'h0));
    wait_for(2, 100);
    n = 0;
    while (dev_reset_out === 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk(n, 32'(RESET_HOLD_CYCLES));
    @(posedge core_clk);
    chk(starts, 32'h1);
    rchk(IDX_CTRL, DEF);
    rchk(IDX_SECURITY, 32'h0);
    repeat (40000) @(posedge core_clk);
    chk(starts, 32'(MAX_STARTUP_ATTEMPTS));
    bus(IDX_IRQ_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h4, 32'h4);
    report_and_stop();
  end
endmodule
